// [mtio_seq.sv]
// discrete-signal motion task sequencer with apb register access
`timescale 1ns/100ps
`default_nettype none
`include "mtio_map.svh"
module mtio_seq #(
    parameter int TICK_DIV = `MTIO_TICK_NS / `MTIO_CLK_NS,
    parameter int ADDR_TICKS = `MTIO_ADDR_TIME_MS * 1000000 / `MTIO_TICK_NS
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // discrete inputs from the controller
    input wire logic [7:0] motion_block_select,
    input wire logic launch_selected_task,
    input wire logic next_task_in,
    input wire logic base_next_in,
    input wire logic jog_request_in,
    input wire logic resume_interrupted_task,
    input wire logic ferr_ack_in,
    // discrete outputs to the controller
    output logic target_reached_out,
    output logic sequence_step_toggle,
    output logic ferr_n_out,
    output logic [5:0] position_window_out,
    // motion core
    input wire mtio_pkg::mtio_mc_t mc_stat,
    output var mtio_pkg::mtio_cmd_t mc_cmd,
    // interrupt
    output logic irq
);
    localparam int NIN = 14;

    // synchronised pins
    logic [NIN-1:0] pin_q;
    logic [NIN-1:0] pin_rise;
    logic [NIN-1:0] pin_fall;
    logic [7:0] sel_q;
    logic launch_rise;
    logic next_rise;
    logic base_rise;
    logic jog_rise;
    logic jog_fall;
    logic resume_rise;
    logic ack_rise;
    logic tick;

    mtio_sync #(
        .W(NIN)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({motion_block_select, launch_selected_task, next_task_in, base_next_in,
            jog_request_in, resume_interrupted_task, ferr_ack_in}),
        .q(pin_q),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    mtio_tick #(
        .DIV(TICK_DIV)
    ) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );

    assign sel_q = pin_q[13:6];
    assign launch_rise = pin_rise[5];
    assign next_rise = pin_rise[4];
    assign base_rise = pin_rise[3];
    assign jog_rise = pin_rise[2];
    assign jog_fall = pin_fall[2];
    assign resume_rise = pin_rise[1];
    assign ack_rise = pin_rise[0];

    // registers
    logic ctrl_en_r;
    logic [`MTIO_JOGSPD_W-1:0] jogspd_r;
    logic [17:0] posfn_r;
    logic [`MTIO_EV_W-1:0] istat_r;
    logic [`MTIO_EV_W-1:0] istat_nxt;
    logic [`MTIO_EV_W-1:0] ien_r;
    logic [`MTIO_EV_W-1:0] ev;
    logic [7:0] last_r;
    logic pending_r;
    mtio_pkg::mtio_state_t state_r;
    mtio_pkg::mtio_state_t state_nxt;

    // apb decode
    logic acc;
    logic setup;
    logic wr;
    logic hit_ctrl;
    logic hit_state;
    logic hit_jog;
    logic hit_posfn;
    logic hit_istat;
    logic hit_iclr;
    logic hit_ien;
    logic hit_last;
    logic hit_any;
    logic [31:0] rd_mux;

    assign acc = psel & penable;
    assign setup = psel & ~penable;
    assign wr = acc & pwrite;
    assign hit_ctrl = (paddr == `MTIO_CTRL_OFS);
    assign hit_state = (paddr == `MTIO_STATE_OFS);
    assign hit_jog = (paddr == `MTIO_JOGSPD_OFS);
    assign hit_posfn = (paddr == `MTIO_POSFN_OFS);
    assign hit_istat = (paddr == `MTIO_ISTAT_OFS);
    assign hit_iclr = (paddr == `MTIO_ICLR_OFS);
    assign hit_ien = (paddr == `MTIO_IEN_OFS);
    assign hit_last = (paddr == `MTIO_LAST_OFS);
    assign hit_any = hit_ctrl | hit_state | hit_jog | hit_posfn | hit_istat | hit_iclr | hit_ien | hit_last;

    // zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = acc & ~hit_any;

    assign rd_mux = hit_ctrl ? {31'h00000000, ctrl_en_r} :
                    hit_state ? {28'h0000000, pending_r, mc_cmd.jog_run, 2'(state_r)} :
                    hit_jog ? {16'h0000, jogspd_r} :
                    hit_posfn ? {14'h0000, posfn_r} :
                    hit_istat ? {26'h0000000, istat_r} :
                    hit_ien ? {26'h0000000, ien_r} :
                    hit_last ? {24'h000000, last_r} : 32'h00000000;

    // read data is captured in the setup phase and held through the access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_en_r <= `MTIO_CTRL_RST;
            jogspd_r <= `MTIO_JOGSPD_RST;
            posfn_r <= `MTIO_POSFN_RST;
            ien_r <= '0;
        end else if (wr) begin
            if (hit_ctrl) begin
                ctrl_en_r <= pwdata[`MTIO_CTRL_EN_BIT];
            end
            if (hit_jog) begin
                jogspd_r <= pwdata[`MTIO_JOGSPD_W-1:0];
            end
            if (hit_posfn) begin
                posfn_r <= pwdata[17:0];
            end
            if (hit_ien) begin
                ien_r <= pwdata[`MTIO_EV_W-1:0];
            end
        end
    end

    // address settle: the select lines must rest for the addressing time
    logic [7:0] sel_prev_r;
    logic [12:0] settle_r;
    logic sel_stable;

    assign sel_stable = (settle_r == 13'(ADDR_TICKS));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_prev_r <= 8'h00;
            settle_r <= 13'h0000;
        end else begin
            sel_prev_r <= sel_q;
            if (sel_q != sel_prev_r) begin
                settle_r <= 13'h0000;
            end else if (tick && !sel_stable) begin
                settle_r <= settle_r + 13'h0001;
            end
        end
    end

    // request qualification
    logic req_next;
    logic launch_ok;
    logic launch_bad;
    logic next_go;
    logic resume_go;
    logic in_win_r;

    // jog owns the axis; discrete task starts are not accepted while it runs
    assign req_next = (next_rise | base_rise) & mc_stat.next_by_io;
    assign launch_ok = launch_rise & ctrl_en_r & sel_stable & (state_r != mtio_pkg::MTIO_JOG);
    assign launch_bad = launch_rise & ~launch_ok;
    assign next_go = (req_next | pending_r) & mc_stat.in_window & ctrl_en_r
                     & (state_r == mtio_pkg::MTIO_TASK) & ~launch_ok;
    assign resume_go = resume_rise & ctrl_en_r & mc_stat.interrupted
                       & (state_r != mtio_pkg::MTIO_JOG) & ~launch_ok & ~next_go;

    // a next request before the target is reached is held, not dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending_r <= 1'b0;
        end else if (next_go || launch_ok || state_r != mtio_pkg::MTIO_TASK) begin
            pending_r <= 1'b0;
        end else if (req_next && !mc_stat.in_window) begin
            pending_r <= 1'b1;
        end
    end

    // sequencer state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            mtio_pkg::MTIO_IDLE: begin
                if (jog_rise && ctrl_en_r) begin
                    state_nxt = mtio_pkg::MTIO_JOG;
                end else if (launch_ok || resume_go) begin
                    state_nxt = mtio_pkg::MTIO_TASK;
                end
            end
            mtio_pkg::MTIO_TASK: begin
                if (jog_rise && ctrl_en_r) begin
                    state_nxt = mtio_pkg::MTIO_JOG;
                end
            end
            mtio_pkg::MTIO_JOG: begin
                if (jog_fall || !ctrl_en_r) begin
                    state_nxt = mtio_pkg::MTIO_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= mtio_pkg::MTIO_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // command outputs to the motion core, one-cycle pulses except jog and the held task number
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mc_cmd <= '0;
            last_r <= 8'h00;
        end else begin
            mc_cmd.start <= launch_ok | next_go;
            mc_cmd.homing <= launch_ok & (sel_q == 8'h00);
            mc_cmd.resume <= resume_go;
            mc_cmd.clear_warn <= ack_rise;
            mc_cmd.jog_run <= (state_nxt == mtio_pkg::MTIO_JOG);
            mc_cmd.jog_speed <= jogspd_r;
            if (launch_ok) begin
                mc_cmd.number <= sel_q;
                last_r <= sel_q;
            end else if (next_go) begin
                mc_cmd.number <= mc_stat.next_num;
                last_r <= mc_stat.next_num;
            end
        end
    end

    // status outputs to the controller
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_win_r <= 1'b0;
            target_reached_out <= 1'b0;
            ferr_n_out <= 1'b1;
            sequence_step_toggle <= 1'b0;
        end else begin
            in_win_r <= mc_stat.in_window;
            target_reached_out <= mc_stat.in_window;
            ferr_n_out <= ~mc_stat.ferr_exceeded;
            if (mc_stat.task_begin && mc_stat.seq_member) begin
                if (mc_stat.seq_first) begin
                    sequence_step_toggle <= 1'b0;
                end else begin
                    sequence_step_toggle <= ~sequence_step_toggle;
                end
            end
        end
    end

    // window outputs select their source per configured function
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_pos
            logic [`MTIO_FN_W-1:0] fn;
            logic src;
            assign fn = posfn_r[gi*`MTIO_FN_W +: `MTIO_FN_W];
            assign src = (fn == `MTIO_FN_SWL1) ? mc_stat.sw_limit1 :
                         (fn == `MTIO_FN_SWL2) ? mc_stat.sw_limit2 :
                         (fn == `MTIO_FN_TARGET_REACHED_OUT) ? mc_stat.in_window :
                         (fn == `MTIO_FN_FERR) ? mc_stat.ferr_exceeded : 1'b0;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    position_window_out[gi] <= 1'b0;
                end else begin
                    position_window_out[gi] <= src;
                end
            end
        end
    endgenerate

    // interrupt events; a new event wins over a clear in the same cycle
    logic ferr_prev_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ferr_prev_r <= 1'b0;
        end else begin
            ferr_prev_r <= mc_stat.ferr_exceeded;
        end
    end

    assign ev[`MTIO_EV_START] = launch_ok | next_go;
    assign ev[`MTIO_EV_REACHED] = mc_stat.in_window & ~in_win_r;
    assign ev[`MTIO_EV_FERR] = mc_stat.ferr_exceeded & ~ferr_prev_r;
    assign ev[`MTIO_EV_REFUSED] = launch_bad;
    assign ev[`MTIO_EV_JOG] = jog_rise & ctrl_en_r;
    assign ev[`MTIO_EV_RESUME] = resume_go;

    assign istat_nxt = (istat_r & ~((wr && hit_iclr) ? pwdata[`MTIO_EV_W-1:0] : '0)) | ev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_r <= '0;
            irq <= 1'b0;
        end else begin
            istat_r <= istat_nxt;
            irq <= |(istat_nxt & ien_r);
        end
    end
endmodule : mtio_seq
`default_nettype wire

// [mtio_map.svh]
// register offsets, field positions, reset values and timing counts of the motion task sequencer
`ifndef MTIO_MAP_SVH
`define MTIO_MAP_SVH

// register byte offsets
`define MTIO_CTRL_OFS 8'h00
`define MTIO_STATE_OFS 8'h04
`define MTIO_JOGSPD_OFS 8'h08
`define MTIO_POSFN_OFS 8'h0C
`define MTIO_ISTAT_OFS 8'h10
`define MTIO_ICLR_OFS 8'h14
`define MTIO_IEN_OFS 8'h18
`define MTIO_LAST_OFS 8'h1C

// control fields
`define MTIO_CTRL_EN_BIT 0
`define MTIO_CTRL_RST 1'h1

// window output function codes, three bits per output
`define MTIO_FN_W 3
`define MTIO_FN_LOW 3'h0
`define MTIO_FN_SWL1 3'h1
`define MTIO_FN_SWL2 3'h2
`define MTIO_FN_TARGET_REACHED_OUT 3'h3
`define MTIO_FN_FERR 3'h4
`define MTIO_POSFN_RST 18'h00088

// event bits of the interrupt status
`define MTIO_EV_W 6
`define MTIO_EV_START 0
`define MTIO_EV_REACHED 1
`define MTIO_EV_FERR 2
`define MTIO_EV_REFUSED 3
`define MTIO_EV_JOG 4
`define MTIO_EV_RESUME 5

`define MTIO_JOGSPD_W 16
`define MTIO_JOGSPD_RST 16'h0000

// timing
`define MTIO_CLK_NS 20
`define MTIO_TICK_NS 1000
`define MTIO_ADDR_TIME_MS 4

`endif

// [mtio_pkg.sv]
// types shared by the motion task sequencer files
`default_nettype none
package mtio_pkg;

    typedef enum logic [1:0] {
        MTIO_IDLE,
        MTIO_TASK,
        MTIO_JOG
    } mtio_state_t;

    // status reported by the motion core
    typedef struct packed {
        logic in_window;
        logic ferr_exceeded;
        logic sw_limit1;
        logic sw_limit2;
        logic task_begin;
        logic seq_member;
        logic seq_first;
        logic next_by_io;
        logic [7:0] next_num;
        logic interrupted;
    } mtio_mc_t;

    // commands issued to the motion core
    typedef struct packed {
        logic start;
        logic homing;
        logic resume;
        logic clear_warn;
        logic jog_run;
        logic [7:0] number;
        logic [15:0] jog_speed;
    } mtio_cmd_t;

endpackage : mtio_pkg
`default_nettype wire

// [mtio_sync.sv]
// two-stage synchroniser with edge detection on the synchronised sample
`timescale 1ns/100ps
`default_nettype none
module mtio_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // raw pins
    input wire logic [W-1:0] d,
    // synchronised level and edges
    output logic [W-1:0] q,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    // first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    assign q = s2_r;
    assign rise = s2_r & ~s3_r;
    assign fall = ~s2_r & s3_r;
endmodule : mtio_sync
`default_nettype wire

// [mtio_tick.sv]
// divider that issues a one-cycle enable every DIV clocks
`timescale 1ns/100ps
`default_nettype none
module mtio_tick #(
    parameter int DIV = 50
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // enable pulse
    output logic tick
);
    logic [15:0] cnt_r;
    logic wrap;

    assign wrap = (cnt_r == 16'(DIV - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 16'h0000;
            tick <= 1'b0;
        end else begin
            cnt_r <= wrap ? 16'h0000 : cnt_r + 16'h0001;
            tick <= wrap;
        end
    end
endmodule : mtio_tick
`default_nettype wire

// [mtio_checker.sv]
// port assertions of the motion task sequencer
`timescale 1ns/100ps
`default_nettype none
module mtio_checker (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // controller pins
    input wire logic launch_selected_task,
    input wire logic jog_request_in,
    input wire logic ferr_ack_in,
    input wire logic target_reached_out,
    input wire logic sequence_step_toggle,
    input wire logic ferr_n_out,
    // motion core
    input wire mtio_pkg::mtio_mc_t mc_stat,
    input wire mtio_pkg::mtio_cmd_t mc_cmd
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_reach; 1'b1 |=> target_reached_out == $past(mc_stat.in_window); endproperty
    a_reach: assert property (p_reach) else $error("target reached output does not follow window");
    property p_ferr; 1'b1 |=> ferr_n_out == !$past(mc_stat.ferr_exceeded); endproperty
    a_ferr: assert property (p_ferr) else $error("following error output wrong");
    property p_home; mc_cmd.homing |-> mc_cmd.start && mc_cmd.number == 8'h00; endproperty
    a_home: assert property (p_home) else $error("homing without start or number zero");
    property p_first; mc_stat.task_begin && mc_stat.seq_first |=> !sequence_step_toggle; endproperty
    a_first: assert property (p_first) else $error("step output not low on first task");
    property p_toggle; mc_stat.task_begin && mc_stat.seq_member && !mc_stat.seq_first
        |=> sequence_step_toggle != $past(sequence_step_toggle); endproperty
    a_toggle: assert property (p_toggle) else $error("step output did not invert");
    property p_jog_stop; $fell(jog_request_in) |-> ##[1:6] !mc_cmd.jog_run; endproperty
    a_jog_stop: assert property (p_jog_stop) else $error("jog not cancelled");
    property p_ack; $rose(ferr_ack_in) |-> ##[2:6] mc_cmd.clear_warn; endproperty
    a_ack: assert property (p_ack) else $error("warning clear not issued");
    // an unsynchronised path would answer the pin within two edges
    property p_sync; $rose(launch_selected_task) |-> ##1 !mc_cmd.start [*2]; endproperty
    a_sync: assert property (p_sync) else $error("launch acted before synchronising");
endmodule : mtio_checker

bind mtio_seq mtio_checker mtio_checker_inst (.pclk(pclk), .presetn(presetn),
    .launch_selected_task(launch_selected_task), .jog_request_in(jog_request_in), .ferr_ack_in(ferr_ack_in),
    .target_reached_out(target_reached_out), .sequence_step_toggle(sequence_step_toggle),
    .ferr_n_out(ferr_n_out), .mc_stat(mc_stat), .mc_cmd(mc_cmd));
`default_nettype wire

// [mtio_core_model.sv]
// behavioural motion core answering the sequencer's commands
`timescale 1ns/100ps
`default_nettype none
module mtio_core_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // sequencer side
    input wire mtio_pkg::mtio_cmd_t mc_cmd,
    output var mtio_pkg::mtio_mc_t mc_stat,
    // static status fields and settling time set by the bench
    input wire mtio_pkg::mtio_mc_t knobs,
    input wire logic [7:0] reach
);
    logic [7:0] cnt_r;
    logic busy_r;
    logic win_r;
    logic begin_r;
    logic first_r;
    // a new or resumed task leaves the window until the countdown ends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 8'h00;
            busy_r <= 1'b0;
            win_r <= 1'b0;
            begin_r <= 1'b0;
            first_r <= 1'b1;
        end else begin
            begin_r <= mc_cmd.start;
            if (begin_r) begin
                first_r <= !knobs.seq_member;
            end
            if (mc_cmd.start || mc_cmd.resume) begin
                cnt_r <= reach;
                busy_r <= 1'b1;
                win_r <= 1'b0;
            end else if (busy_r && cnt_r == 8'h00) begin
                busy_r <= 1'b0;
                win_r <= 1'b1;
            end else if (busy_r) begin
                cnt_r <= cnt_r - 8'h01;
            end
        end
    end
    always_comb begin
        mc_stat = knobs;
        mc_stat.in_window = win_r;
        mc_stat.task_begin = begin_r;
        mc_stat.seq_first = begin_r && first_r && knobs.seq_member;
    end
endmodule : mtio_core_model
`default_nettype wire

// [mtio_tb.sv]
// self-checking bench of the motion task sequencer
`timescale 1ns/100ps
`default_nettype none
`include "mtio_map.svh"
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, sel = 8'h00, reach = 8'h03;
    logic [31:0] pwdata = 32'h00000000, prdata, rdv, word, rnd;
    logic pready, pslverr, tro, sst, ferr_n, irq, hit, err, cap_win, exp_t;
    logic [5:0] pins = 6'h00, pwo;
    logic [2:0] fn [6] = '{`MTIO_FN_LOW, `MTIO_FN_SWL1, `MTIO_FN_SWL2, `MTIO_FN_LOW, `MTIO_FN_LOW, `MTIO_FN_LOW};
    mtio_pkg::mtio_mc_t mc_stat, knobs = '0;
    mtio_pkg::mtio_cmd_t mc_cmd, cap;
    integer seed = 79;
    int err_count = 0, samples_checked = 0, cycles = 0;

    mtio_seq #(.TICK_DIV(2), .ADDR_TICKS(2)) mtio_seq_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .motion_block_select(sel), .launch_selected_task(pins[0]), .next_task_in(pins[1]),
        .base_next_in(pins[2]), .resume_interrupted_task(pins[3]), .ferr_ack_in(pins[4]),
        .jog_request_in(pins[5]), .target_reached_out(tro), .sequence_step_toggle(sst), .ferr_n_out(ferr_n),
        .position_window_out(pwo), .mc_stat(mc_stat), .mc_cmd(mc_cmd), .irq(irq));
    mtio_core_model mtio_core_model_inst (.pclk(pclk), .presetn(presetn), .mc_cmd(mc_cmd), .mc_stat(mc_stat),
        .knobs(knobs), .reach(reach));

    always #10 pclk = ~pclk;

    task automatic summarize();
        if (err_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    // a hang ends in the report instead of running forever
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            err_count++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // k picks the event: start, resume, clear, jog on, jog off
    task automatic wait_ev(input int k, input int n);
        logic [4:0] ev;
        hit = 1'b0;
        repeat (n) begin
            @(posedge pclk);
            ev = {!mc_cmd.jog_run, mc_cmd.jog_run, mc_cmd.clear_warn, mc_cmd.resume, mc_cmd.start};
            if (!hit && ev[k] === 1'b1) begin
                hit = 1'b1;
                cap = mc_cmd;
                cap_win = mc_stat.in_window;
            end
        end
    endtask : wait_ev

    task automatic pulse_pin(input int p, input int k, input int n);
        pins[p] <= 1'b1;
        wait_ev(k, n);
        pins[p] <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask : pulse_pin

    // the number must rest on the pins before the launch edge
    task automatic launch(input logic [7:0] s);
        sel <= s;
        repeat (12) @(posedge pclk);
        pulse_pin(0, 0, 12);
    endtask : launch

    function automatic logic win_exp(input logic [2:0] f, input mtio_pkg::mtio_mc_t s);
        case (f)
            `MTIO_FN_SWL1: return s.sw_limit1;
            `MTIO_FN_SWL2: return s.sw_limit2;
            `MTIO_FN_TARGET_REACHED_OUT: return s.in_window;
            `MTIO_FN_FERR: return s.ferr_exceeded;
            default: return 1'b0;
        endcase
    endfunction : win_exp

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `MTIO_POSFN_OFS, 32'h0);
        chk(rdv, 32'h00000088);
        apb(1'b0, 8'h20, 32'h0);
        chk({rdv[30:0], err}, 32'h00000001);
        for (int i = 0; i < 10; i++) begin
            word = (i == 0) ? 32'h00000000 : (i == 1) ? 32'h000000AE : $random(seed);
            launch(word[7:0]);
            chk(hit, 1'b1);
            chk(cap.number, word[7:0]);
            chk(cap.homing, word[7:0] == 8'h00);
        end
        apb(1'b0, `MTIO_LAST_OFS, 32'h0);
        chk(rdv, {24'h000000, word[7:0]});
        // three members, a stand-alone task, then a new sequence starting from a low output
        for (int i = 0; i < 6; i++) begin
            knobs.seq_member <= (i != 3);
            launch(8'h10 + 8'(i));
            exp_t = (i == 3) ? exp_t : (i == 0 || i == 4) ? 1'b0 : !exp_t;
            chk(sst, exp_t);
        end
        knobs.seq_member <= 1'b0;
        for (int j = 0; j < 8; j++) begin
            if (j == 4) begin
                fn = '{`MTIO_FN_TARGET_REACHED_OUT, `MTIO_FN_FERR, `MTIO_FN_SWL1, `MTIO_FN_SWL2, `MTIO_FN_TARGET_REACHED_OUT, `MTIO_FN_FERR};
                word = 32'h00000000;
                for (int i = 0; i < 6; i++) word[3*i +: 3] = fn[i];
                apb(1'b1, `MTIO_POSFN_OFS, word);
            end
            rnd = $random(seed);
            knobs.ferr_exceeded <= rnd[0];
            knobs.sw_limit1 <= rnd[1];
            knobs.sw_limit2 <= rnd[2];
            repeat (3) @(posedge pclk);
            chk(tro, mc_stat.in_window);
            chk(ferr_n, !mc_stat.ferr_exceeded);
            for (int i = 0; i < 6; i++) chk(pwo[i], win_exp(fn[i], mc_stat));
        end
        reach <= 8'h28;
        knobs.next_by_io <= 1'b1;
        knobs.next_num <= rnd[15:8];
        launch(8'h21);
        pulse_pin(1, 0, 12);
        chk(hit, 1'b0);
        chk(tro, 1'b0);
        wait_ev(0, 60);
        chk({hit, cap_win}, 2'h3);
        chk(cap.number, knobs.next_num);
        pulse_pin(2, 0, 70);
        chk({hit, cap.number}, {1'b1, knobs.next_num});
        knobs.next_by_io <= 1'b0;
        reach <= 8'h03;
        apb(1'b1, `MTIO_IEN_OFS, 32'h1 << `MTIO_EV_REFUSED);
        apb(1'b1, `MTIO_JOGSPD_OFS, {16'h0000, rnd[31:16]});
        pins[5] <= 1'b1;
        wait_ev(3, 12);
        chk(hit, 1'b1);
        chk(cap.jog_speed, rnd[31:16]);
        launch(8'h33);
        chk({hit, irq}, 2'h1);
        apb(1'b1, `MTIO_ICLR_OFS, 32'h1 << `MTIO_EV_REFUSED);
        @(posedge pclk);
        chk(irq, 1'b0);
        pins[5] <= 1'b0;
        wait_ev(4, 12);
        chk(hit, 1'b1);
        for (int k = 0; k < 2; k++) begin
            knobs.interrupted <= k[0];
            pulse_pin(3, 1, 12);
            chk(hit, k[0]);
        end
        apb(1'b1, `MTIO_CTRL_OFS, 32'h0);
        launch(8'h05);
        chk({hit, irq}, 2'h1);
        apb(1'b1, `MTIO_CTRL_OFS, 32'h1);
        pulse_pin(4, 2, 12);
        chk(hit, 1'b1);
        summarize();
    end
endmodule : tb
`default_nettype wire
